// [delta_sigma_converter_consts.vh]
// Behaviour
// - converter ready five clocks after modulator enable
// - conversion clock gated by stop bit, divided
// - conversion lasts 2640 clocks plus first delay
// - clock gated off after shutdown in low power
// - single converts once, repeat converts continuously
// - writing one to start bit triggers conversion
// - busy while converting, end flag cleared by read
// - busy stays set throughout repeat operation
// - clearing repeat aborts without end interrupt
// - completion raises interrupt, stores result, sets flag
// - overwrite of unread result sets overrun flag
// - results are two's complement sample codes
// - stop slave first; follow bit decouples master
// - result in bits 31-8, previous during conversion
`ifndef DELTA_SIGMA_CONVERTER_CONSTS_VH
`define DELTA_SIGMA_CONVERTER_CONSTS_VH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_REF 8'h00
`define OFS_CLKGATE 8'h04
`define OFS_CLKDIV 8'h08
`define OFS_POWER 8'h0c
`define OFS_START 8'h10
`define OFS_MODE 8'h14
`define OFS_GAIN 8'h18
`define OFS_STATUS 8'h1c
`define OFS_RESULT 8'h20
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_REF_ON 0
`define BIT_AMP_ON 1
`define BIT_BIAS 0
`define BIT_MOD 1
`define BIT_REPEAT 0
`define BIT_FOLLOW 1
`define BIT_START 0
`define BIT_BUSY 0
`define BIT_END 1
`define BIT_STORED 0
`define BIT_OVERRUN 1
// ----------------------------------------------------------------
// timing counts in conversion clock cycles
// ----------------------------------------------------------------
`define READY_CYC 3'd5
`define CONV_CYC 16'd2640
`define FIRST_DELAY_CYC 16'd674
`define DIV_RESET 8'h00
`define GAIN_RESET 3'h0
`endif

// [clock_divider.v]
`timescale 1ns/100ps
// conversion clock tick generator: one tick every div+1 system cycles
module clock_divider (
    input wire clk_i,
    input wire rst_i,
    input wire gate_off_i,
    input wire [7:0] div_i,
    output reg tick_o
);
    reg [7:0] cnt_r; // divider count

    // ------------------------------------------------------------
    // divider
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= 8'h00;
            tick_o <= 1'b0;
        end else if (gate_off_i) begin
            // gated: no ticks, counter parked
            cnt_r <= 8'h00;
            tick_o <= 1'b0;
        end else if (cnt_r >= div_i) begin
            cnt_r <= 8'h00;
            tick_o <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 8'h01;
            tick_o <= 1'b0;
        end
    end
endmodule // clock_divider

// [delta_sigma_converter_seq.v]
`timescale 1ns/100ps
`include "delta_sigma_converter_consts.vh"
// delta-sigma converter sequencer with register port
module delta_sigma_converter_seq (
    input wire CLOCK_I,
    input wire RST_I,
    input wire [7:0] ADDR_I,
    input wire [31:0] WDATA_I,
    input wire WR_I,
    input wire RD_I,
    input wire SYNC_START_I,
    input wire SAMPLE_VALID_I,
    input wire [23:0] SAMPLE_I,
    output reg [31:0] RDATA_O,
    output reg END_IRQ_O,
    output reg SYNC_START_O,
    output reg REF_ON_O,
    output reg AMP_ON_O,
    output reg BIAS_ON_O,
    output reg MOD_ON_O,
    output reg [2:0] GAIN_O,
    output reg CONV_CLK_TICK_O,
    output reg CONVERTING_O
);
    // ------------------------------------------------------------
    // state codes
    // ------------------------------------------------------------
    localparam ST_IDLE = 2'd0;
    localparam ST_DELAY = 2'd1;
    localparam ST_CONV = 2'd2;

    // registers
    reg [1:0] ref_r; // amplifier and reference enables
    reg gate_off_r; // converter clock gate off
    reg [7:0] div_r; // conversion clock divider
    reg [1:0] pwr_r; // bias and modulator enables
    reg [1:0] mode_r; // repeat and follow
    reg [2:0] gain_r; // amplifier gain
    reg busy_r; // conversion in progress
    reg end_r; // conversion end flag
    reg stored_r; // result stored flag
    reg ovr_r; // overrun flag
    reg [23:0] res_r; // last result
    reg [1:0] state_r; // sequencer state
    reg [15:0] cnt_r; // conversion clock cycle count
    reg [2:0] ready_r; // cycles since modulator on
    reg pending_r; // start waiting for ready
    reg sync_m_r; // synchroniser first stage
    reg sync_s_r; // synchroniser second stage
    reg sync_d_r; // delayed for edge detect
    reg [23:0] sample_r; // latched modulator sample
    reg repeat_started_r; // run was launched in repeat mode
    wire tick; // conversion clock tick
    wire sync_rise;
    wire start_wr;
    wire start_req;
    wire ready;
    wire done;

    // ------------------------------------------------------------
    // conversion clock
    // ------------------------------------------------------------
    // gated and divided clock
    clock_divider u_div (
        .clk_i(CLOCK_I),
        .rst_i(RST_I),
        .gate_off_i(gate_off_r),
        .div_i(div_r),
        .tick_o(tick)
    );

    // address match used by several decoders
    function hit;
        input [7:0] a;
        input [7:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    assign start_wr = WR_I && hit(ADDR_I, `OFS_START) &&
        WDATA_I[`BIT_START];
    assign sync_rise = sync_s_r && !sync_d_r;
    assign start_req = start_wr || (mode_r[`BIT_FOLLOW] && sync_rise);
    assign ready = pwr_r[`BIT_MOD] && (ready_r == `READY_CYC);
    assign done = (state_r == ST_CONV) && tick && (cnt_r == 16'd1);

    // ------------------------------------------------------------
    // synchroniser for external master start
    // ------------------------------------------------------------
    always @(posedge CLOCK_I) begin
        if (RST_I) begin
            sync_m_r <= 1'b0;
            sync_s_r <= 1'b0;
            sync_d_r <= 1'b0;
        end else begin
            sync_m_r <= SYNC_START_I;
            sync_s_r <= sync_m_r;
            sync_d_r <= sync_s_r;
        end
    end

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always @(posedge CLOCK_I) begin
        if (RST_I) begin
            ref_r <= 2'b00;
            gate_off_r <= 1'b0;
            div_r <= `DIV_RESET;
            pwr_r <= 2'b00;
            mode_r <= 2'b00;
            gain_r <= `GAIN_RESET;
        end else if (WR_I) begin
            case (ADDR_I)
                `OFS_REF: ref_r <= WDATA_I[1:0];
                `OFS_CLKGATE: gate_off_r <= WDATA_I[0];
                `OFS_CLKDIV: div_r <= WDATA_I[7:0];
                `OFS_POWER: pwr_r <= WDATA_I[1:0];
                // whole field written; software keeps others
                `OFS_MODE: mode_r <= WDATA_I[1:0];
                `OFS_GAIN: gain_r <= WDATA_I[2:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // modulator warm-up counter
    // ------------------------------------------------------------
    always @(posedge CLOCK_I) begin
        if (RST_I || !pwr_r[`BIT_MOD]) begin
            ready_r <= 3'd0;
        end else if (tick && ready_r != `READY_CYC) begin
            ready_r <= ready_r + 3'd1;
        end
    end

    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------
    always @(posedge CLOCK_I) begin
        if (RST_I) begin
            state_r <= ST_IDLE;
            cnt_r <= 16'd0;
            busy_r <= 1'b0;
            pending_r <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    // start bit triggers; held until ready
                    if ((start_req || pending_r) && ready &&
                        tick) begin
                        state_r <= ST_DELAY;
                        cnt_r <= `FIRST_DELAY_CYC;
                        busy_r <= 1'b1;
                        pending_r <= 1'b0;
                    end else if (start_req) begin
                        pending_r <= 1'b1;
                        busy_r <= 1'b1;
                    end
                end
                ST_DELAY: begin
                    if (!pwr_r[`BIT_MOD]) begin
                        state_r <= ST_IDLE;
                        busy_r <= 1'b0;
                    end else if (tick) begin
                        if (cnt_r == 16'd1) begin
                            state_r <= ST_CONV;
                            cnt_r <= `CONV_CYC;
                        end else begin
                            cnt_r <= cnt_r - 16'd1;
                        end
                    end
                end
                ST_CONV: begin
                    // abort when repeat is cleared mid-run
                    if (busy_r && repeat_started_r &&
                        !mode_r[`BIT_REPEAT]) begin
                        state_r <= ST_IDLE;
                        busy_r <= 1'b0;
                    end else if (!pwr_r[`BIT_MOD]) begin
                        state_r <= ST_IDLE;
                        busy_r <= 1'b0;
                    end else if (done) begin
                        if (mode_r[`BIT_REPEAT]) begin
                            // no extra delay after the first
                            cnt_r <= `CONV_CYC;
                        end else begin
                            state_r <= ST_IDLE;
                            // busy drops only when run ends
                            busy_r <= 1'b0;
                        end
                    end else if (tick) begin
                        cnt_r <= cnt_r - 16'd1;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    busy_r <= 1'b0;
                end
            endcase
        end
    end

    // remembers that this run was launched in repeat mode
    always @(posedge CLOCK_I) begin
        if (RST_I) begin
            repeat_started_r <= 1'b0;
        end else if (state_r == ST_IDLE) begin
            repeat_started_r <= mode_r[`BIT_REPEAT];
        end
    end

    // ------------------------------------------------------------
    // sample capture from the modulator filter
    // ------------------------------------------------------------
    always @(posedge CLOCK_I) begin
        if (RST_I) begin
            sample_r <= 24'h000000;
        end else if (SAMPLE_VALID_I) begin
            // code taken as two's complement unchanged
            sample_r <= SAMPLE_I;
        end
    end

    // ------------------------------------------------------------
    // completion flags; a set wins over a read clear
    // ------------------------------------------------------------
    always @(posedge CLOCK_I) begin
        if (RST_I) begin
            end_r <= 1'b0;
            stored_r <= 1'b0;
            ovr_r <= 1'b0;
            res_r <= 24'h000000;
            END_IRQ_O <= 1'b0;
        end else begin
            END_IRQ_O <= done;
            // end flag set at finish, read clears
            if (done) begin
                end_r <= 1'b1;
            end else if (RD_I && hit(ADDR_I, `OFS_STATUS)) begin
                end_r <= 1'b0;
            end
            if (done) begin
                res_r <= sample_r;
                stored_r <= 1'b1;
                if (stored_r && !(RD_I && hit(ADDR_I, `OFS_RESULT))) begin
                    ovr_r <= 1'b1;
                end
            end else if (RD_I && hit(ADDR_I, `OFS_RESULT)) begin
                stored_r <= 1'b0;
                ovr_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // read data, one cycle after the strobe
    // ------------------------------------------------------------
    always @(posedge CLOCK_I) begin
        if (RST_I) begin
            RDATA_O <= 32'h00000000;
        end else if (RD_I) begin
            case (ADDR_I)
                `OFS_REF: RDATA_O <= {30'h0, ref_r};
                `OFS_CLKGATE: RDATA_O <= {31'h0, gate_off_r};
                `OFS_CLKDIV: RDATA_O <= {24'h0, div_r};
                `OFS_POWER: RDATA_O <= {30'h0, pwr_r};
                `OFS_MODE: RDATA_O <= {30'h0, mode_r};
                `OFS_GAIN: RDATA_O <= {29'h0, gain_r};
                `OFS_STATUS: RDATA_O <= {30'h0, end_r, busy_r};
                `OFS_RESULT: RDATA_O <= {res_r, 6'h00, ovr_r, stored_r};
                default: RDATA_O <= 32'h00000000;
            endcase
        end else begin
            RDATA_O <= 32'h00000000;
        end
    end

    // ------------------------------------------------------------
    // analog control outputs
    // ------------------------------------------------------------
    always @(posedge CLOCK_I) begin
        if (RST_I) begin
            REF_ON_O <= 1'b0;
            AMP_ON_O <= 1'b0;
            BIAS_ON_O <= 1'b0;
            MOD_ON_O <= 1'b0;
            GAIN_O <= `GAIN_RESET;
            CONV_CLK_TICK_O <= 1'b0;
            CONVERTING_O <= 1'b0;
            SYNC_START_O <= 1'b0;
        end else begin
            REF_ON_O <= ref_r[`BIT_REF_ON];
            AMP_ON_O <= ref_r[`BIT_AMP_ON];
            BIAS_ON_O <= pwr_r[`BIT_BIAS];
            MOD_ON_O <= pwr_r[`BIT_MOD];
            GAIN_O <= gain_r;
            // tick stops while the gate is off
            CONV_CLK_TICK_O <= tick;
            CONVERTING_O <= (state_r == ST_CONV);
            // master start forwarded only by a non-follower
            SYNC_START_O <= start_wr && !mode_r[`BIT_FOLLOW];
        end
    end
endmodule // delta_sigma_converter_seq

// [delta_sigma_converter_seq_props.sv]
`timescale 1ns/100ps
`include "delta_sigma_converter_consts.vh"
// ---------------------------------------------
// port-level property checker of the sequencer
// ---------------------------------------------
module delta_sigma_converter_seq_props (
    input wire CLOCK_I,
    input wire RST_I,
    input wire [7:0] ADDR_I,
    input wire [31:0] WDATA_I,
    input wire WR_I,
    input wire RD_I,
    input wire SYNC_START_I,
    input wire SAMPLE_VALID_I,
    input wire [23:0] SAMPLE_I,
    input wire [31:0] RDATA_O,
    input wire END_IRQ_O,
    input wire SYNC_START_O,
    input wire REF_ON_O,
    input wire AMP_ON_O,
    input wire BIAS_ON_O,
    input wire MOD_ON_O,
    input wire [2:0] GAIN_O,
    input wire CONV_CLK_TICK_O,
    input wire CONVERTING_O
);
    reg rep_r; // repeat bit as software last wrote it
    reg fol_r; // follow bit as software last wrote it
    reg [11:0] cnt_r; // ticks seen in the current conversion
    wire wr_mode = WR_I && ADDR_I == `OFS_MODE;
    wire wr_start = WR_I && ADDR_I == `OFS_START;
    wire rd_st = RD_I && ADDR_I == `OFS_STATUS;
    wire rd_res = RD_I && ADDR_I == `OFS_RESULT;
    // mode shadow and tick count; a restart clears the count so
    // an aborted run leaves nothing behind for the next one
    always @(posedge CLOCK_I) begin
        if (RST_I) begin
            rep_r <= 1'b0;
            fol_r <= 1'b0;
            cnt_r <= 12'h000;
        end else begin
            if (wr_mode) begin
                rep_r <= WDATA_I[`BIT_REPEAT];
                fol_r <= WDATA_I[`BIT_FOLLOW];
            end
            if (END_IRQ_O || wr_mode || wr_start) cnt_r <= 12'h000;
            else if (CONV_CLK_TICK_O && CONVERTING_O)
                cnt_r <= cnt_r + 12'h001;
        end
    end
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);
    property p_irq_pulse; END_IRQ_O |=> !END_IRQ_O; endproperty
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("end pulse lasts more than a cycle");
    property p_conv_len;
        END_IRQ_O |-> cnt_r == 12'd2639;
    endproperty
    a_conv_len: assert property (p_conv_len)
        else $error("conversion length out of range");
    property p_abort;
        wr_mode && rep_r && !WDATA_I[`BIT_REPEAT] && CONVERTING_O
            |=> !END_IRQ_O [*8] ##0 !CONVERTING_O;
    endproperty
    a_abort: assert property (p_abort)
        else $error("repeat clear did not abort quietly");
    property p_single_stop;
        END_IRQ_O && !rep_r |-> ##2 !CONVERTING_O;
    endproperty
    a_single_stop: assert property (p_single_stop)
        else $error("single conversion did not stop");
    // the conversion output lags the state by a cycle, so both cycles
    // must show it before the busy bit is owed
    property p_busy;
        rd_st && CONVERTING_O ##1 CONVERTING_O |-> RDATA_O[`BIT_BUSY];
    endproperty
    a_busy: assert property (p_busy)
        else $error("busy flag low while converting");
    property p_end_clear;
        rd_st && !END_IRQ_O && !$past(END_IRQ_O) ##1 rd_st && !END_IRQ_O
            ##1 !END_IRQ_O |-> !RDATA_O[`BIT_END];
    endproperty
    a_end_clear: assert property (p_end_clear)
        else $error("end flag survived a status read");
    property p_res_clear;
        rd_res && !END_IRQ_O && !$past(END_IRQ_O) ##1 rd_res && !END_IRQ_O
            ##1 !END_IRQ_O |-> RDATA_O[7:0] == 8'h00 && $stable(RDATA_O[31:8]);
    endproperty
    a_res_clear: assert property (p_res_clear)
        else $error("result flags survived a result read");
    property p_sync;
        wr_start && WDATA_I[`BIT_START] && !fol_r |-> ##[1:2] SYNC_START_O;
    endproperty
    a_sync: assert property (p_sync)
        else $error("leader start sent no sync pulse");
    property p_gate;
        WR_I && ADDR_I == `OFS_CLKGATE && WDATA_I[0]
            |-> ##3 !CONV_CLK_TICK_O [*8];
    endproperty
    a_gate: assert property (p_gate)
        else $error("conversion clock ticks while gated");
endmodule // delta_sigma_converter_seq_props
bind delta_sigma_converter_seq delta_sigma_converter_seq_props chk (.CLOCK_I(CLOCK_I), .RST_I(RST_I),
    .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
    .SYNC_START_I(SYNC_START_I), .SAMPLE_VALID_I(SAMPLE_VALID_I),
    .SAMPLE_I(SAMPLE_I), .RDATA_O(RDATA_O), .END_IRQ_O(END_IRQ_O),
    .SYNC_START_O(SYNC_START_O), .REF_ON_O(REF_ON_O), .AMP_ON_O(AMP_ON_O),
    .BIAS_ON_O(BIAS_ON_O), .MOD_ON_O(MOD_ON_O), .GAIN_O(GAIN_O),
    .CONV_CLK_TICK_O(CONV_CLK_TICK_O), .CONVERTING_O(CONVERTING_O));

// [sample_source.sv]
`timescale 1ns/100ps
// ---------------------------------------------
// filter sample source on the far side
// ---------------------------------------------
module sample_source (
    input wire clk_i,
    input wire rst_i,
    input wire [23:0] code_i,
    output reg valid_o,
    output reg [23:0] sample_o
);
    reg [1:0] cnt_r; // spaces samples four cycles apart
    always @(posedge clk_i) begin
        cnt_r <= rst_i ? 2'h0 : cnt_r + 2'h1;
        valid_o <= !rst_i && cnt_r == 2'h3;
        // off the valid cycle the bus carries junk, never a stale copy
        sample_o <= cnt_r == 2'h3 ? code_i : ~code_i;
    end
endmodule // sample_source

// [test_delta_sigma_converter_seq.sv]
`timescale 1ns/100ps
`include "delta_sigma_converter_consts.vh"
module test_delta_sigma_converter_seq;
    reg clk = 1'b0; // system clock
    reg rst = 1'b1; // synchronous reset
    reg [7:0] addr = 8'h00; // register bus, driven at the rising edge
    reg [31:0] wdata = 32'h0;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg sync_in = 1'b0; // start pulse from a leader unit
    reg [23:0] code = 24'h0; // value the sample source reports
    wire [31:0] rdata;
    wire irq, sync_out, ref_on, amp_on, bias_on, mod_on, tick, conv, svalid;
    wire [2:0] gain;
    wire [23:0] sample;
    integer errors = 0;
    integer comparisons = 0;
    integer n, k;
    reg [31:0] seed = 32'h000124b7; // fixed seed, runs repeat
    reg [31:0] q0, q1; // two back-to-back read results
    reg [2:0] g; // gain under test
    delta_sigma_converter_seq uut (.CLOCK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .SYNC_START_I(sync_in), .SAMPLE_VALID_I(svalid),
        .SAMPLE_I(sample), .RDATA_O(rdata), .END_IRQ_O(irq),
        .SYNC_START_O(sync_out), .REF_ON_O(ref_on), .AMP_ON_O(amp_on),
        .BIAS_ON_O(bias_on), .MOD_ON_O(mod_on), .GAIN_O(gain),
        .CONV_CLK_TICK_O(tick), .CONVERTING_O(conv));
    sample_source src (.clk_i(clk), .rst_i(rst), .code_i(code),
        .valid_o(svalid), .sample_o(sample));
    always #2 clk = ~clk;
    function [31:0] xs(input [31:0] s);
        xs = s ^ (s << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    endfunction
    // result word: code in the top bits, flags at the bottom
    function [31:0] res_word(input [23:0] c, input [1:0] f);
        res_word = {c, 6'h00, f};
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task wr_reg(input [7:0] a, input [31:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
        end
    endtask
    // two reads with no gap, so read-to-clear shows in the second
    task rd2(input [7:0] a);
        begin
            @(posedge clk);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            #1 q0 = rdata;
            @(posedge clk);
            rd <= 1'b0;
            #1 q1 = rdata;
        end
    endtask
    task wait_irq(input integer lim);
        begin
            n = 0;
            do begin
                @(posedge clk);
                #1 n = n + 1;
            end while (irq !== 1'b1 && n < lim);
        end
    endtask
    task count_ticks;
        begin
            repeat (4) @(posedge clk);
            n = 0;
            repeat (16) begin
                @(posedge clk);
                #1 n = n + tick;
            end
        end
    endtask
    task summarize;
        begin
            $display("comparisons=%0d errors=%0d", comparisons, errors);
            if (errors == 0 && comparisons > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    // watchdog: about two and a half times the expected run
    initial begin
        #(4 * 60000);
        errors = errors + 1;
        summarize;
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd2(`OFS_STATUS);
        chk(q0, 32'h0);
        rd2(8'hfc); // unmapped place reads zero
        chk(q0 | q1, 32'h0);
        // clock changes only while bias and modulator are off
        wr_reg(`OFS_CLKDIV, 32'h1);
        wr_reg(`OFS_CLKGATE, 32'h1);
        count_ticks;
        chk(n, 0);
        wr_reg(`OFS_CLKGATE, 32'h0);
        count_ticks;
        chk(n, 8);
        wr_reg(`OFS_CLKDIV, 32'h0);
        // boot; settling waits shortened to keep the run brief
        wr_reg(`OFS_REF, 32'h3);
        repeat (100) @(posedge clk);
        wr_reg(`OFS_POWER, 32'h1);
        repeat (100) @(posedge clk);
        seed = xs(seed);
        g = seed[2:0] % 3'h5;
        wr_reg(`OFS_MODE, 32'h0);
        wr_reg(`OFS_GAIN, {29'h0, g});
        wr_reg(`OFS_POWER, 32'h3);
        repeat (2) @(posedge clk);
        #1 chk({ref_on, amp_on, bias_on, mod_on, gain}, {4'hf, g});
        // single conversions; the first waits for the modulator
        for (k = 0; k < 3; k = k + 1) begin
            seed = xs(seed);
            code = k == 0 ? 24'h4fc2bf : k == 1 ? 24'h000000 : seed[23:0];
            wr_reg(`OFS_START, 32'h1);
            #1 chk(sync_out, 1);
            wait_irq(50);
            rd2(`OFS_STATUS);
            chk(q1, 32'h1);
            wait_irq(3400);
            chk(n + 53 >= 3313 && n + 53 <= 3326, 1);
            rd2(`OFS_STATUS);
            chk(q0, 32'h2);
            chk(q1, 32'h0);
            // the middle result stays unread, so the last overruns
            if (k != 1) begin
                rd2(`OFS_RESULT);
                chk(q0, res_word(code, {k == 2, 1'b1}));
                chk(q1, res_word(code, 2'h0));
            end
        end
        // repeat mode: later conversions carry no fixed delay
        code = 24'hb03d41;
        wr_reg(`OFS_MODE, 32'h1);
        wr_reg(`OFS_START, 32'h1);
        wait_irq(3400);
        wait_irq(3400);
        chk(n, 2640);
        seed = xs(seed);
        code = seed[23:0];
        rd2(`OFS_STATUS);
        chk(q1, 32'h1);
        rd2(`OFS_RESULT);
        chk(q0, res_word(24'hb03d41, 2'h3));
        // only the repeat bit changes in the stopping write
        wr_reg(`OFS_MODE, 32'h0);
        wait_irq(3000);
        chk(n, 3000);
        rd2(`OFS_STATUS);
        chk(q0, 32'h0);
        // follower starts on the leader's pulse
        // leader shares our clock, biases after us
        wr_reg(`OFS_MODE, 32'h2);
        sync_in <= 1'b1;
        repeat (4) @(posedge clk);
        sync_in <= 1'b0;
        wait_irq(3400);
        chk(n < 3400, 1);
        // shutdown from idle: modulator, bias, then reference
        rd2(`OFS_STATUS);
        chk(q1, 32'h0);
        wr_reg(`OFS_POWER, 32'h1);
        wr_reg(`OFS_POWER, 32'h0);
        wr_reg(`OFS_REF, 32'h0);
        repeat (2) @(posedge clk);
        #1 chk({ref_on, amp_on, bias_on, mod_on}, 32'h0);
        summarize;
    end
endmodule // test_delta_sigma_converter_seq
